//--- gptc_pkg.sv
// Package with register map, field layout and state types of the timer.
package gptc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] GPTC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] GPTC_OFF_CMD    = 8'h04;
	localparam logic [7:0] GPTC_OFF_INIT   = 8'h08;
	localparam logic [7:0] GPTC_OFF_DELAY  = 8'h0C;
	localparam logic [7:0] GPTC_OFF_WIDTH  = 8'h10;
	localparam logic [7:0] GPTC_OFF_COUNT  = 8'h14;
	localparam logic [7:0] GPTC_OFF_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int GPTC_CMD_START_BIT = 0;
	localparam int GPTC_CMD_RESET_BIT = 1;
	localparam int GPTC_CTRL_WIDTH    = 8;
	localparam logic [31:0] GPTC_RST_WORD = 32'h0000_0000;
	localparam logic [3:0] GPTC_MODE_NONE = 4'h0;
	localparam logic [3:0] GPTC_MODE_GATED_EVENT = 4'h1;
	localparam logic [3:0] GPTC_MODE_PERIOD = 4'h2;
	localparam logic [3:0] GPTC_MODE_PULSE_WIDTH = 4'h3;
	localparam logic [3:0] GPTC_MODE_GATED_PULSE = 4'h4;
	localparam logic [3:0] GPTC_MODE_TRIG_PULSE = 4'h5;
	localparam logic [3:0] GPTC_MODE_RETRIG_PULSE = 4'h6;
	localparam logic [3:0] GPTC_MODE_TRIG_TRAIN = 4'h7;
	localparam logic [3:0] GPTC_MODE_GATED_TRAIN = 4'h8;
	localparam logic [3:0] GPTC_MODE_PWM = 4'h9;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// A polarity bit of one means the signal is active low.
	typedef struct packed {
		logic       out_pol;
		logic       gate_pol;
		logic       clk_pol;
		logic       clk_external;
		logic [3:0] mode;
	} gptc_ctrl_type;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} gptc_edge_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARMED,
		ST_MEAS,
		ST_DELAY,
		ST_WIDTH,
		ST_DONE
	} gptc_state_type;

endpackage

//--- gptc_sync.sv
// Two-stage pin synchroniser with polarity and edge detection.
`timescale 1ns/1ns
`default_nettype none
module gptc_sync (
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire logic                    pin,
	input  wire logic                    invert,
	output gptc_pkg::gptc_edge_type      sig
);
	import gptc_pkg::*;

	logic meta;
	logic stable;
	logic prev;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end else begin
			meta   <= pin;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign sig.level = stable ^ invert;
	assign sig.rise  = (stable ^ invert) & ~(prev ^ invert);
	assign sig.fall  = ~(stable ^ invert) & (prev ^ invert);

endmodule // gptc_sync
`default_nettype wire

//--- gptc_core.sv
// General purpose timer/counter with measurement, pulse and PWM modes.
// Overview of operation
// [R1] Nine modes; idle until software start.
// [R2] Software reset clears status, reloads initial count.
// [R3] Mode 1 counts clock edges, holds when gated.
// [R4] Count readable anytime without disturbing counting.
// [R5] Mode 2 counts between gate edges, output high.
// [R6] Mode 3 counts during gate, then output high.
// [R7] Mode 4 one delayed pulse, freezes when gated.
// [R8] Mode 5 one pulse after first gate edge.
// [R9] Mode 6 pulse per gate edge, busy edges ignored.
// [R10] Mode 7 pulse train after first gate edge.
// [R11] Mode 8 pulse train, freezes when gated.
// [R12] PWM period is delay plus width.
// [R13] PWM delay and width changes apply immediately.
// [R14] Direction pin high counts up, low down.
// [R15] Clock, gate, output polarity software selectable.
// [R16] Count clock internal or external pin.
// [R17] Pins synchronised and edge detected before use.
// [R18] Finished measurement holds output high, count frozen.
`timescale 1ns/1ns
`default_nettype none
module gptc_core (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        counter_clock_in,
	input  wire logic        counter_gate_in,
	input  wire logic        count_direction_in,
	output logic             counter_pulse_out
);
	import gptc_pkg::*;

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	gptc_ctrl_type  ctrl;
	logic [31:0]    init_count;
	logic [31:0]    pulse_delay_count;
	logic [31:0]    pulse_width_count;
	logic [31:0]    count;
	logic [31:0]    pcnt;
	gptc_state_type state;
	logic [31:0]    next_count;
	logic [31:0]    next_pcnt;
	gptc_state_type next_state;
	gptc_edge_type  clk_sig;
	gptc_edge_type  gate_sig;
	gptc_edge_type  dir_sig;

	wire wr_ctrl  = reg_wr && (reg_addr == GPTC_OFF_CTRL);
	wire wr_cmd   = reg_wr && (reg_addr == GPTC_OFF_CMD);
	wire wr_init  = reg_wr && (reg_addr == GPTC_OFF_INIT);
	wire wr_delay = reg_wr && (reg_addr == GPTC_OFF_DELAY);
	wire wr_width = reg_wr && (reg_addr == GPTC_OFF_WIDTH);
	wire cmd_reset = wr_cmd && reg_wdata[GPTC_CMD_RESET_BIT];
	wire cmd_start = wr_cmd && reg_wdata[GPTC_CMD_START_BIT] && !cmd_reset;
	wire no_cmd    = !cmd_reset && !cmd_start;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl              <= gptc_ctrl_type'(GPTC_RST_WORD[7:0]);
			init_count        <= GPTC_RST_WORD;
			pulse_delay_count <= GPTC_RST_WORD;
			pulse_width_count <= GPTC_RST_WORD;
		end else begin
			if (wr_ctrl)
				ctrl <= gptc_ctrl_type'(reg_wdata[GPTC_CTRL_WIDTH-1:0]); // [R15]
			if (wr_init)
				init_count <= reg_wdata;
			if (wr_delay)
				pulse_delay_count <= reg_wdata; // [R13]
			if (wr_width)
				pulse_width_count <= reg_wdata; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// Pin conditioning
	// ----------------------------------------------------------------
	gptc_sync u_clk_sync (// [R17]
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (counter_clock_in),
		.invert   (ctrl.clk_pol),
		.sig      (clk_sig)
	);
	gptc_sync u_gate_sync (// [R17]
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (counter_gate_in),
		.invert   (ctrl.gate_pol),
		.sig      (gate_sig)
	);
	gptc_sync u_dir_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (count_direction_in),
		.invert   (1'b0),
		.sig      (dir_sig)
	);

	// The internal source steps on every logic clock.
	wire tick = ctrl.clk_external ? clk_sig.rise : 1'b1; // [R16]
	wire gate_act = gate_sig.level;
	wire [3:0] mode = ctrl.mode;
	wire [31:0] count_step = dir_sig.level ? count + 32'h1 // [R14]
		: count - 32'h1;
	wire [31:0] pcnt_inc = pcnt + 32'h1;
	wire gated_mode = (mode == GPTC_MODE_GATED_PULSE) ||
		(mode == GPTC_MODE_GATED_TRAIN);
	wire meas_mode = (mode == GPTC_MODE_PERIOD) ||
		(mode == GPTC_MODE_PULSE_WIDTH);
	wire phase_adv = tick && (!gated_mode || gate_act); // [R7] [R11]
	wire delay_end = pcnt_inc >= pulse_delay_count;
	wire width_end = pcnt_inc >= pulse_width_count;
	wire out_level = (state == ST_WIDTH) ||
		((state == ST_DONE) && meas_mode);

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_count = count;
		next_pcnt  = pcnt;
		if (cmd_reset) begin
			next_state = ST_IDLE; // [R2]
			next_count = init_count;
			next_pcnt  = 32'h0;
		end else if (cmd_start) begin
			next_count = init_count;
			next_pcnt  = 32'h0;
			case (mode) // [R1]
			GPTC_MODE_GATED_EVENT: next_state = ST_MEAS;
			GPTC_MODE_PERIOD,
			GPTC_MODE_PULSE_WIDTH,
			GPTC_MODE_TRIG_PULSE,
			GPTC_MODE_RETRIG_PULSE,
			GPTC_MODE_TRIG_TRAIN: next_state = ST_ARMED;
			GPTC_MODE_GATED_PULSE,
			GPTC_MODE_GATED_TRAIN,
			GPTC_MODE_PWM: next_state = ST_DELAY;
			default: next_state = ST_IDLE;
			endcase
		end else begin
			case (state)
			ST_ARMED: begin
				if (gate_sig.rise) // [R8] [R9] [R10]
					next_state = meas_mode ? ST_MEAS : ST_DELAY;
			end
			ST_MEAS: begin
				if (mode == GPTC_MODE_PERIOD && gate_sig.rise)
					next_state = ST_DONE; // [R5]
				else if (mode == GPTC_MODE_PULSE_WIDTH && gate_sig.fall)
					next_state = ST_DONE; // [R6]
				else if (tick && (gate_act || mode == GPTC_MODE_PERIOD))
					next_count = count_step; // [R3] [R4]
			end
			ST_DELAY: begin
				if (phase_adv) begin
					next_count = count_step;
					next_pcnt  = delay_end ? 32'h0 : pcnt_inc;
					if (delay_end)
						next_state = ST_WIDTH; // [R12]
				end
			end
			ST_WIDTH: begin
				if (phase_adv) begin
					next_count = count_step;
					next_pcnt  = width_end ? 32'h0 : pcnt_inc;
					if (width_end) begin
						case (mode)
						GPTC_MODE_GATED_PULSE,
						GPTC_MODE_TRIG_PULSE: next_state = ST_DONE;
						GPTC_MODE_RETRIG_PULSE: next_state = ST_ARMED;
						default: next_state = ST_DELAY; // [R10] [R11] [R12]
						endcase
					end
				end
			end
			ST_DONE: next_state = ST_DONE; // [R18]
			default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			count <= GPTC_RST_WORD;
			pcnt  <= GPTC_RST_WORD;
		end else begin
			state <= next_state;
			count <= next_count;
			pcnt  <= next_pcnt;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			counter_pulse_out <= 1'b0;
		else
			counter_pulse_out <= out_level ^ ctrl.out_pol; // [R15]
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	wire running = (state != ST_IDLE) && (state != ST_DONE);
	wire [31:0] status_word = {29'h0, out_level, state == ST_DONE, running};
	wire [31:0] rd_mux =
		(reg_addr == GPTC_OFF_CTRL)   ? {24'h0, ctrl} :
		(reg_addr == GPTC_OFF_INIT)   ? init_count :
		(reg_addr == GPTC_OFF_DELAY)  ? pulse_delay_count :
		(reg_addr == GPTC_OFF_WIDTH)  ? pulse_width_count :
		(reg_addr == GPTC_OFF_COUNT)  ? count :
		(reg_addr == GPTC_OFF_STATUS) ? status_word : 32'h0;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= GPTC_RST_WORD;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0; // [R4]
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_idle_hold;
		state == ST_IDLE && !cmd_start |=> state == ST_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) // [R1]
		else $error("Counter left idle without a start.");

	property p_sw_reset;
		cmd_reset |=> state == ST_IDLE && count == $past(init_count);
	endproperty
	a_sw_reset: assert property (p_sw_reset) // [R2]
		else $error("Software reset did not reload the count.");

	property p_gate_hold;
		state == ST_MEAS && mode == GPTC_MODE_GATED_EVENT && !gate_act
			&& no_cmd |=> $stable(count);
	endproperty
	a_gate_hold: assert property (p_gate_hold) // [R3]
		else $error("Count moved while the gate was inactive.");

	property p_count_read;
		reg_rd && reg_addr == GPTC_OFF_COUNT |=>
			reg_rdata == $past(count) && state == $past(next_state);
	endproperty
	a_count_read: assert property (p_count_read) // [R4]
		else $error("Count read returned the wrong value.");

	property p_period_done;
		state == ST_MEAS && mode == GPTC_MODE_PERIOD && gate_sig.rise
			&& no_cmd |=> state == ST_DONE ##1
			(counter_pulse_out != ctrl.out_pol || $past(cmd_reset));
	endproperty
	a_period_done: assert property (p_period_done) // [R5]
		else $error("Period measurement did not finish on the gate edge.");

	property p_width_done;
		state == ST_MEAS && mode == GPTC_MODE_PULSE_WIDTH && gate_sig.fall
			&& no_cmd |=> state == ST_DONE;
	endproperty
	a_width_done: assert property (p_width_done) // [R6]
		else $error("Pulse-width measurement did not finish.");

	property p_gated_freeze;
		state == ST_DELAY && gated_mode && !gate_act && no_cmd
			|=> state == ST_DELAY && $stable(pcnt);
	endproperty
	a_gated_freeze: assert property (p_gated_freeze) // [R7]
		else $error("Delay advanced while the gate was inactive.");

	property p_retrig_busy;
		state == ST_DELAY && mode == GPTC_MODE_RETRIG_PULSE && no_cmd
			|=> state inside {ST_DELAY, ST_WIDTH};
	endproperty
	a_retrig_busy: assert property (p_retrig_busy) // [R9]
		else $error("Retrigger interrupted a pulse in progress.");

	property p_pwm_wrap;
		state == ST_WIDTH && mode == GPTC_MODE_PWM && tick && width_end
			&& no_cmd |=> state == ST_DELAY && pcnt == 32'h0;
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap) // [R12]
		else $error("PWM width phase did not wrap to delay.");

	c_period: cover property (state == ST_MEAS &&
		mode == GPTC_MODE_PERIOD ##1 state == ST_DONE);
	c_pwm: cover property (state == ST_WIDTH && mode == GPTC_MODE_PWM
		##1 state == ST_DELAY);
	c_rearm: cover property (state == ST_WIDTH &&
		mode == GPTC_MODE_RETRIG_PULSE ##1 state == ST_ARMED);

endmodule // gptc_core
`default_nettype wire

//--- gptc_ext_model.sv
// Model of the connector side: count clock, gate and direction sources.
`timescale 1ns/1ns
`default_nettype none
module gptc_ext_model (
	input  wire logic core_clk,
	output logic      counter_clock_in,
	output logic      counter_gate_in,
	output logic      count_direction_in
);
	initial begin
		counter_clock_in   = 1'b0;
		counter_gate_in    = 1'b0;
		count_direction_in = 1'b0;
	end

	// Each level lasts three logic clocks so that the synchroniser sees it.
	task automatic clk_pulses(input int n);
		repeat (n) begin
			@(posedge core_clk) counter_clock_in <= 1'b1;
			repeat (3) @(posedge core_clk);
			counter_clock_in <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
		repeat (3) @(posedge core_clk);
	endtask

	task automatic set_gate(input logic v);
		@(posedge core_clk) counter_gate_in <= v;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic set_dir(input logic v);
		@(posedge core_clk) count_direction_in <= v;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic gate_pulse(input int h);
		@(posedge core_clk) counter_gate_in <= 1'b1;
		repeat (h) @(posedge core_clk);
		counter_gate_in <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
endmodule // gptc_ext_model
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the timer/counter block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import gptc_pkg::*;
	logic        core_clk;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	wire logic   counter_clock_in;
	wire logic   counter_gate_in;
	wire logic   count_direction_in;
	logic        counter_pulse_out;
	logic [31:0] d;
	int          n_mismatch;
	int          samples_checked;
	int          hi;
	int          lo;

	gptc_core gptc_core_i (
		.core_clk           (core_clk),
		.resetn             (resetn),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.counter_clock_in   (counter_clock_in),
		.counter_gate_in    (counter_gate_in),
		.count_direction_in (count_direction_in),
		.counter_pulse_out  (counter_pulse_out)
	);
	gptc_ext_model gptc_ext_model_i (
		.core_clk           (core_clk),
		.counter_clock_in   (counter_clock_in),
		.counter_gate_in    (counter_gate_in),
		.count_direction_in (count_direction_in)
	);

	always #20 core_clk = ~core_clk;

	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input string nm,
		input logic [31:0] e);
		rd(a);
		check(nm, d, e);
	endtask

	task automatic run(input logic [7:0] c, input logic [31:0] i, dl, w);
		wr(GPTC_OFF_CMD, 32'h2);
		wr(GPTC_OFF_CTRL, {24'h0, c});
		wr(GPTC_OFF_INIT, i);
		wr(GPTC_OFF_DELAY, dl);
		wr(GPTC_OFF_WIDTH, w);
		wr(GPTC_OFF_CMD, 32'h1);
	endtask

	// Counts cycles at the active level and entries into it.
	task automatic window(input int n, input logic act, output int h, r);
		logic p;
		h = 0;
		r = 0;
		p = counter_pulse_out;
		repeat (n) begin
			@(posedge core_clk) #1;
			if (counter_pulse_out === act) h++;
			if (counter_pulse_out === act && p !== act) r++;
			p = counter_pulse_out;
		end
	endtask

	// Measures one whole active phase and the idle phase after it.
	task automatic measure(input logic act, output int h, l);
		int k;
		k = 0;
		while (counter_pulse_out === act && k < 100) begin
			@(posedge core_clk) #1 k++;
		end
		while (counter_pulse_out !== act && k < 200) begin
			@(posedge core_clk) #1 k++;
		end
		h = 0;
		while (counter_pulse_out === act && h < 100) begin
			@(posedge core_clk) #1 h++;
		end
		l = 0;
		while (counter_pulse_out !== act && l < 100) begin
			@(posedge core_clk) #1 l++;
		end
	endtask

	task automatic t_reset();
		check("pin", counter_pulse_out, 32'h0);
		rdc(GPTC_OFF_CTRL, "ctrl", 32'h0);
		rdc(GPTC_OFF_COUNT, "count", 32'h0);
		rdc(8'h1C, "unmapped", 32'h0);
		wr(GPTC_OFF_CMD, 32'h1);
		rdc(GPTC_OFF_STATUS, "mode0", 32'h0);
	endtask

	task automatic t_count();
		gptc_ext_model_i.set_gate(1'b1);
		wr(GPTC_OFF_CTRL, {24'h0, 4'h1, GPTC_MODE_GATED_EVENT});
		wr(GPTC_OFF_INIT, 32'h5);
		gptc_ext_model_i.clk_pulses(2);
		rdc(GPTC_OFF_COUNT, "prestart", 32'h0);
		wr(GPTC_OFF_CMD, 32'h1);
		gptc_ext_model_i.clk_pulses(3);
		rdc(GPTC_OFF_COUNT, "down", 32'h2);
		gptc_ext_model_i.set_gate(1'b0);
		gptc_ext_model_i.clk_pulses(2);
		rdc(GPTC_OFF_COUNT, "gated", 32'h2);
		gptc_ext_model_i.set_gate(1'b1);
		gptc_ext_model_i.set_dir(1'b1);
		fork
			gptc_ext_model_i.clk_pulses(4);
			repeat (6) rd(GPTC_OFF_COUNT);
		join
		rdc(GPTC_OFF_COUNT, "up", 32'h6);
		wr(GPTC_OFF_CMD, 32'h2);
		rdc(GPTC_OFF_COUNT, "reload", 32'h5);
		@(posedge core_clk) #1;
		check("rdidle", reg_rdata, 32'h0);
		rdc(GPTC_OFF_STATUS, "stclr", 32'h0);
		gptc_ext_model_i.clk_pulses(2);
		rdc(GPTC_OFF_COUNT, "halted", 32'h5);
		wr(GPTC_OFF_CTRL, {24'h0, 4'h5, GPTC_MODE_GATED_EVENT});
		gptc_ext_model_i.set_gate(1'b0);
		wr(GPTC_OFF_CMD, 32'h1);
		gptc_ext_model_i.clk_pulses(2);
		rdc(GPTC_OFF_COUNT, "gatepol", 32'h7);
		run({4'h0, GPTC_MODE_GATED_EVENT}, 32'h5, 32'h0, 32'h0);
		gptc_ext_model_i.set_gate(1'b1);
		repeat (20) @(posedge core_clk);
		gptc_ext_model_i.set_gate(1'b0);
		rd(GPTC_OFF_COUNT);
		check("internal", {31'h0, d > 32'h14}, 32'h1);
	endtask

	task automatic t_measure();
		run({4'h1, GPTC_MODE_PERIOD}, 32'h0, 32'h0, 32'h0);
		gptc_ext_model_i.gate_pulse(3);
		gptc_ext_model_i.clk_pulses(4);
		gptc_ext_model_i.gate_pulse(3);
		check("pdone", counter_pulse_out, 32'h1);
		rdc(GPTC_OFF_COUNT, "period", 32'h4);
		rd(GPTC_OFF_STATUS);
		check("stdone", d[1], 32'h1);
		gptc_ext_model_i.clk_pulses(2);
		gptc_ext_model_i.gate_pulse(3);
		rdc(GPTC_OFF_COUNT, "frozen", 32'h4);
		check("phold", counter_pulse_out, 32'h1);
		run({4'h1, GPTC_MODE_PULSE_WIDTH}, 32'h0, 32'h0, 32'h0);
		gptc_ext_model_i.set_gate(1'b1);
		check("wstart", counter_pulse_out, 32'h0);
		gptc_ext_model_i.clk_pulses(3);
		gptc_ext_model_i.set_gate(1'b0);
		@(negedge core_clk);
		check("wdone", counter_pulse_out, 32'h1);
		rdc(GPTC_OFF_COUNT, "width", 32'h3);
	endtask

	task automatic t_pulses();
		int r;
		run({4'h0, GPTC_MODE_GATED_PULSE}, 32'h0, 32'h2, 32'h4);
		window(20, 1'b1, hi, r);
		check("m4gated", r, 32'h0);
		fork
			gptc_ext_model_i.set_gate(1'b1);
			window(30, 1'b1, hi, r);
		join
		check("m4n", r, 32'h1);
		check("m4w", hi, 32'h4);
		gptc_ext_model_i.set_gate(1'b0);
		run({4'h0, GPTC_MODE_TRIG_PULSE}, 32'h0, 32'h2, 32'h4);
		for (int i = 0; i < 2; i++) begin
			fork
				gptc_ext_model_i.gate_pulse(2);
				window(30, 1'b1, hi, r);
			join
			check("m5n", r, 32'(1 - i));
		end
		run({4'h0, GPTC_MODE_RETRIG_PULSE}, 32'h0, 32'h2, 32'h8);
		fork
			begin
				gptc_ext_model_i.gate_pulse(1);
				gptc_ext_model_i.gate_pulse(1);
			end
			window(40, 1'b1, hi, r);
		join
		check("m6busy", r, 32'h1);
		fork
			gptc_ext_model_i.gate_pulse(2);
			window(30, 1'b1, hi, r);
		join
		check("m6n", r, 32'h1);
		check("m6w", hi, 32'h8);
		run({4'h0, GPTC_MODE_TRIG_TRAIN}, 32'h0, 32'h4, 32'h3);
		gptc_ext_model_i.gate_pulse(2);
		measure(1'b1, hi, lo);
		gptc_ext_model_i.gate_pulse(2);
		measure(1'b1, hi, lo);
		check("m7w", hi, 32'h3);
		check("m7d", lo, 32'h4);
		gptc_ext_model_i.set_gate(1'b1);
		run({4'h8, GPTC_MODE_GATED_TRAIN}, 32'h0, 32'h4, 32'h3);
		measure(1'b0, hi, lo);
		check("m8w", hi, 32'h3);
		check("m8d", lo, 32'h4);
		gptc_ext_model_i.set_gate(1'b0);
		window(20, 1'b0, hi, r);
		check("m8gated", r, 32'h0);
	endtask

	task automatic t_pwm();
		run({4'h0, GPTC_MODE_PWM}, 32'h0, 32'h2, 32'h4);
		measure(1'b1, hi, lo);
		check("pwmw", hi, 32'h4);
		check("pwmd", lo, 32'h2);
		rd(GPTC_OFF_STATUS);
		check("running", d[0], 32'h1);
		wr(GPTC_OFF_WIDTH, 32'h1);
		measure(1'b1, hi, lo);
		check("cofw", hi, 32'h1);
		wr(GPTC_OFF_DELAY, 32'h5);
		measure(1'b1, hi, lo);
		check("cofd", lo, 32'h5);
	endtask

	initial begin
		core_clk        = 1'b0;
		resetn          = 1'b0;
		reg_addr        = 8'h00;
		reg_wdata       = 32'h0;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		n_mismatch      = 0;
		samples_checked = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_count();
		t_measure();
		t_pulses();
		t_pwm();
		results();
	end

	initial begin
		#2000000;
		n_mismatch++;
		results();
	end
endmodule // tb_top
`default_nettype wire
